// >>> cce_exec.sv
// Operation
// - clear_acc_op loads accumulator with 00h and sets null flag only.
// - subroutine_jump_op pushes fetch_pointer plus one onto the return stack.
// - subroutine_jump_op loads the 8-bit literal into fetch_pointer low bits.
// - subroutine_jump_op copies flags bits 6:5 to pointer 10:9, clears bit 8.
// - subroutine_jump_op takes two cycles and leaves every flag unchanged.
// - kick_supervisor_op resets the supervisor_timer count to 00h.
// - kick also clears prescaler, only while prescaler serves the supervisor_timer.
// - kick_supervisor_op sets expiry_flag_n and sleep_flag_n to one.
// - clear_file_op writes 00h to the addressed file register and sets null.
// - destination bit zero targets accumulator, one targets the source file register.
// - invert_file_op stores the complement and updates the null flag.
// - minus_one_file_op stores file minus one and updates the null flag.
// - minus_one_skip_null_op on zero result discards next instruction, runs idle_op.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "cce_regs.svh"

module cce_exec import cce_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic sup_count_clear,
	output logic prescaler_clear
);

	function automatic cce_op_t decode_op(input logic [3:0] opc);
		cce_op_t op;
		unique case (opc)
			`CCE_OPC_CLR_ACC: op = OP_CLR_ACC;
			`CCE_OPC_KICK: op = OP_KICK;
			`CCE_OPC_CLR_FILE: op = OP_CLR_FILE;
			`CCE_OPC_INVERT: op = OP_INVERT;
			`CCE_OPC_MINUS: op = OP_MINUS;
			`CCE_OPC_MINUS_SKIP: op = OP_MINUS_SKIP;
			`CCE_OPC_JUMP: op = OP_JUMP;
			default: op = OP_IDLE;
		endcase
		return op;
	endfunction

	function automatic logic is_file_addr(input logic [7:0] addr);
		return addr[`CCE_FILE_SEL_BIT] && (addr[1:0] == 2'h0);
	endfunction

	function automatic logic [4:0] file_index(input logic [7:0] addr);
		return addr[6:2];
	endfunction

	function automatic logic [7:0] lane0_merge(input logic [7:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		return strb[0] ? data[7:0] : old;
	endfunction

	function automatic logic is_mapped(input logic [7:0] addr);
		return is_file_addr(addr) || addr == `CCE_ADDR_INSTR || addr == `CCE_ADDR_ACC ||
			addr == `CCE_ADDR_FPTR || addr == `CCE_ADDR_FLAGS || addr == `CCE_ADDR_STACK ||
			addr == `CCE_ADDR_CFG || addr == `CCE_ADDR_STATE;
	endfunction

	// architectural state
	logic [7:0] file_mem [`CCE_FILE_DEPTH];
	logic [7:0] acc_q;
	logic [7:0] flags_q;
	logic [7:0] cfg_q;
	logic [`CCE_FP_W-1:0] fp_q;
	logic [`CCE_FP_W-1:0] stack_q [`CCE_STACK_DEPTH];
	cce_state_t state_q;
	logic [`CCE_INSTR_W-1:0] last_instr_q;
	logic sup_clear_q;
	logic presc_clear_q;

	// bus holding state
	logic aw_hold_q;
	logic [7:0] aw_addr_q;
	logic w_hold_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// decoded instruction
	logic wr_go;
	logic instr_go;
	logic [`CCE_INSTR_W-1:0] instr;
	cce_op_t op;
	logic dest_file;
	logic [4:0] f_addr;
	logic [7:0] f_val;
	logic [7:0] alu_res;
	logic alu_null;
	logic to_file;
	logic to_acc;
	logic skip_taken;
	logic [`CCE_FP_W-1:0] fp_next_seq;

	// write address and data are caught independently, in either order
	assign s_axi_awready = !aw_hold_q;
	assign s_axi_wready = !w_hold_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign sup_count_clear = sup_clear_q;
	assign prescaler_clear = presc_clear_q;

	// an instruction write waits while the flush cycle runs; bready stall also holds it
	assign wr_go = aw_hold_q && w_hold_q && !bvalid_q &&
		(state_q == ST_RUN || aw_addr_q != `CCE_ADDR_INSTR);
	assign instr_go = wr_go && aw_addr_q == `CCE_ADDR_INSTR;
	assign instr = w_data_q[`CCE_INSTR_W-1:0];
	assign op = decode_op(instr[`CCE_OPC_HI:`CCE_OPC_LO]);
	assign dest_file = instr[`CCE_INSTR_DEST];
	assign f_addr = instr[`CCE_FILE_HI:0];
	assign f_val = file_mem[f_addr];
	assign fp_next_seq = fp_q + `CCE_FP_STEP;

	cce_alu cce_alu_i (
		.op(op),
		.operand(f_val),
		.result(alu_res),
		.null_out(alu_null)
	);

	always_comb begin
		to_file = 1'b0;
		to_acc = 1'b0;
		if (instr_go) begin
			unique case (op)
				OP_CLR_ACC: to_acc = 1'b1;
				OP_CLR_FILE: to_file = 1'b1;
				OP_INVERT, OP_MINUS, OP_MINUS_SKIP: begin
					to_file = dest_file;
					to_acc = !dest_file;
				end
				OP_IDLE, OP_KICK, OP_JUMP: begin
					to_file = 1'b0;
					to_acc = 1'b0;
				end
			endcase
		end
	end

	assign skip_taken = instr_go && op == OP_MINUS_SKIP && alu_null;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (wr_go) begin
			aw_hold_q <= 1'b0;
		end else if (s_axi_awvalid && !aw_hold_q) begin
			aw_hold_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (wr_go) begin
			w_hold_q <= 1'b0;
		end else if (s_axi_wvalid && !w_hold_q) begin
			w_hold_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `CCE_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= is_mapped(aw_addr_q) ? `CCE_RESP_OKAY : `CCE_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// file registers: bus write and instruction write never coincide
	always_ff @(posedge aclk) begin
		if (wr_go && is_file_addr(aw_addr_q)) begin
			file_mem[file_index(aw_addr_q)] <= lane0_merge(file_mem[file_index(aw_addr_q)], w_data_q, w_strb_q);
		end else if (to_file) begin
			file_mem[f_addr] <= alu_res;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= `CCE_CLEAR_VALUE;
		end else if (to_acc) begin
			acc_q <= alu_res;
		end else if (wr_go && aw_addr_q == `CCE_ADDR_ACC) begin
			acc_q <= lane0_merge(acc_q, w_data_q, w_strb_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= `CCE_FLAGS_RESET;
		end else if (instr_go) begin
			unique case (op)
				OP_CLR_ACC, OP_CLR_FILE: begin
					flags_q[`CCE_FLAG_NULL] <= 1'b1;
				end
				OP_INVERT, OP_MINUS: begin
					flags_q[`CCE_FLAG_NULL] <= alu_null;
				end
				OP_KICK: begin
					flags_q[`CCE_FLAG_EXPIRY_N] <= 1'b1;
					flags_q[`CCE_FLAG_SLEEP_N] <= 1'b1;
				end
				OP_MINUS_SKIP, OP_JUMP, OP_IDLE: begin
					flags_q <= flags_q;
				end
			endcase
		end else if (wr_go && aw_addr_q == `CCE_ADDR_FLAGS) begin
			flags_q <= lane0_merge(flags_q, w_data_q, w_strb_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= `CCE_CFG_RESET;
		end else if (wr_go && aw_addr_q == `CCE_ADDR_CFG) begin
			cfg_q <= lane0_merge(cfg_q, w_data_q, w_strb_q);
		end
	end

	// fetch pointer; the flush cycle of a skip executes an idle_op and steps once more
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fp_q <= '0;
		end else if (state_q == ST_FLUSH) begin
			if (last_instr_q[`CCE_OPC_HI:`CCE_OPC_LO] == `CCE_OPC_MINUS_SKIP) begin
				fp_q <= fp_next_seq;
			end
		end else if (instr_go) begin
			if (op == OP_JUMP) begin
				fp_q <= {flags_q[`CCE_FLAG_PAGE_HI:`CCE_FLAG_PAGE_LO], 1'b0,
					instr[`CCE_LIT_HI:0]};
			end else begin
				fp_q <= fp_next_seq;
			end
		end
	end

	// return stack, top at index zero; the oldest entry falls off when full
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `CCE_STACK_DEPTH; i++) begin
				stack_q[i] <= '0;
			end
		end else if (instr_go && op == OP_JUMP) begin
			stack_q[0] <= fp_next_seq;
			for (int i = 1; i < `CCE_STACK_DEPTH; i++) begin
				stack_q[i] <= stack_q[i-1];
			end
		end
	end

	// second instruction cycle for the jump and for a taken skip
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_RUN;
			last_instr_q <= '0;
		end else begin
			unique case (state_q)
				ST_RUN: begin
					if (instr_go) begin
						last_instr_q <= instr;
						if (op == OP_JUMP || skip_taken) begin
							state_q <= ST_FLUSH;
						end
					end
				end
				ST_FLUSH: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// timer internals live elsewhere; these pulses tell them to restart
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sup_clear_q <= 1'b0;
			presc_clear_q <= 1'b0;
		end else begin
			sup_clear_q <= instr_go && op == OP_KICK;
			presc_clear_q <= instr_go && op == OP_KICK && cfg_q[`CCE_CFG_PRESC_TO_SUP];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `CCE_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rresp_q <= is_mapped(s_axi_araddr) ? `CCE_RESP_OKAY : `CCE_RESP_SLVERR;
			if (is_file_addr(s_axi_araddr)) begin
				rdata_q <= {24'h000000, file_mem[file_index(s_axi_araddr)]};
			end else begin
				unique case (s_axi_araddr)
					`CCE_ADDR_INSTR: rdata_q <= {20'h00000, last_instr_q};
					`CCE_ADDR_ACC: rdata_q <= {24'h000000, acc_q};
					`CCE_ADDR_FPTR: rdata_q <= {21'h0, fp_q};
					`CCE_ADDR_FLAGS: rdata_q <= {24'h000000, flags_q};
					`CCE_ADDR_STACK: rdata_q <= {21'h0, stack_q[0]};
					`CCE_ADDR_CFG: rdata_q <= {24'h000000, cfg_q};
					`CCE_ADDR_STATE: rdata_q <= {31'h0, state_q == ST_FLUSH};
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> cce_regs.svh
`ifndef CCE_REGS_SVH
`define CCE_REGS_SVH

// register byte addresses on the bus
`define CCE_ADDR_INSTR 8'h00
`define CCE_ADDR_ACC 8'h04
`define CCE_ADDR_FPTR 8'h08
`define CCE_ADDR_FLAGS 8'h0c
`define CCE_ADDR_STACK 8'h10
`define CCE_ADDR_CFG 8'h14
`define CCE_ADDR_STATE 8'h18
`define CCE_ADDR_FILE_BASE 8'h80
`define CCE_FILE_SEL_BIT 7

// flags register layout
`define CCE_FLAG_PAGE_HI 6
`define CCE_FLAG_PAGE_LO 5
`define CCE_FLAG_EXPIRY_N 4
`define CCE_FLAG_SLEEP_N 3
`define CCE_FLAG_NULL 2
`define CCE_FLAGS_RESET 8'h18

// configuration register layout
`define CCE_CFG_PRESC_TO_SUP 0
`define CCE_CFG_RESET 8'h00

// instruction word layout
`define CCE_INSTR_W 12
`define CCE_OPC_HI 11
`define CCE_OPC_LO 8
`define CCE_INSTR_DEST 5
`define CCE_FILE_HI 4
`define CCE_LIT_HI 7

// opcode field values
`define CCE_OPC_IDLE 4'h0
`define CCE_OPC_CLR_ACC 4'h1
`define CCE_OPC_KICK 4'h2
`define CCE_OPC_CLR_FILE 4'h3
`define CCE_OPC_INVERT 4'h4
`define CCE_OPC_MINUS 4'h5
`define CCE_OPC_MINUS_SKIP 4'h6
`define CCE_OPC_JUMP 4'h7

// sizes and constants
`define CCE_FP_W 11
`define CCE_FP_STEP 11'h001
`define CCE_CLEAR_VALUE 8'h00
`define CCE_MINUS_STEP 8'h01
`define CCE_FILE_DEPTH 32
`define CCE_STACK_DEPTH 2
`define CCE_RESP_OKAY 2'b00
`define CCE_RESP_SLVERR 2'b10

`endif

// >>> cce_pkg.sv
`default_nettype none
package cce_pkg;

	typedef enum logic [2:0] {
		OP_IDLE,
		OP_CLR_ACC,
		OP_KICK,
		OP_CLR_FILE,
		OP_INVERT,
		OP_MINUS,
		OP_MINUS_SKIP,
		OP_JUMP
	} cce_op_t;

	typedef enum logic {
		ST_RUN,
		ST_FLUSH
	} cce_state_t;

endpackage
`default_nettype wire

// >>> cce_alu.sv
`timescale 1ns/100ps
`default_nettype none
`include "cce_regs.svh"

module cce_alu import cce_pkg::*; (
	input wire cce_op_t op,
	input wire logic [7:0] operand,
	output logic [7:0] result,
	output logic null_out
);

	always_comb begin
		unique case (op)
			OP_CLR_ACC, OP_CLR_FILE: begin
				result = `CCE_CLEAR_VALUE;
			end
			OP_INVERT: begin
				result = ~operand;
			end
			OP_MINUS, OP_MINUS_SKIP: begin
				result = operand - `CCE_MINUS_STEP;
			end
			OP_IDLE, OP_KICK, OP_JUMP: begin
				result = operand;
			end
		endcase
		null_out = (result == `CCE_CLEAR_VALUE);
	end

endmodule
`default_nettype wire

// >>> cce_exec_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cce_exec_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sup_count_clear,
	input wire logic prescaler_clear
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
	else $error("write answer dropped");
r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
	else $error("read answer dropped");
r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("read answer late");
ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
	else $error("read taken while busy");
w_take_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##0 !s_axi_wready)
	else $error("write holds not closed");
b_after_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready))
	else $error("answer without held write");
presc_pair_a: assert property (prescaler_clear |-> sup_count_clear)
	else $error("prescaler clear alone");
kick_pulse_a: assert property (sup_count_clear |=> !sup_count_clear)
	else $error("timer clear too long");
kick_cause_a: assert property (sup_count_clear |-> s_axi_bvalid || $past(s_axi_bvalid))
	else $error("timer clear without instruction");
kick_c: cover property (sup_count_clear);
presc_c: cover property (prescaler_clear);
err_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind cce_exec cce_exec_checker cce_exec_checker_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .sup_count_clear, .prescaler_clear);
`default_nettype wire

// >>> cce_exec_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "cce_regs.svh"
module cce_exec_test;
localparam logic [1:0] OK = `CCE_RESP_OKAY;
localparam logic [7:0] A_FL = `CCE_ADDR_FLAGS;
localparam logic [7:0] A_FP = `CCE_ADDR_FPTR;
localparam logic [7:0] A_AC = `CCE_ADDR_ACC;
logic aclk = 1'h0;
logic aresetn = 1'h0;
logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
logic [3:0] s_axi_wstrb = 4'h1;
logic [31:0] s_axi_wdata = 32'h0;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sup_count_clear, prescaler_clear;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [31:0] s_axi_rdata;
int num_errors = 0, checks = 0, nk = 0, np = 0;
logic [1:0] bq[$];
logic [33:0] rq[$];
logic [10:0] fp;
logic [7:0] v, va, fl, res, lit;
logic [4:0] f;
logic [3:0] op;
logic d;
cce_exec cce_exec_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.sup_count_clear, .prescaler_clear);
initial begin
	forever #5 aclk = ~aclk;
end
task chk(input string n, input logic [33:0] e, input logic [33:0] g);
	checks++;
	if (e !== g) begin
		$display("Error %s expected %h seen %h", n, e, g);
		num_errors++;
	end
endtask
task report_and_stop;
	$display("checks %0d errors %0d", checks, num_errors);
	if (num_errors == 0 && checks > 0) begin
		$display("DONE - PASS");
	end else begin
		$display("DONE - FAIL");
	end
	$finish;
endtask
// negedge shows what the next rising edge will take, free of races
always @(negedge aclk) begin
	if (sup_count_clear === 1'h1) nk++;
	if (prescaler_clear === 1'h1) np++;
	if (s_axi_bvalid && s_axi_bready) chk("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
	if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
end
task wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] r);
	logic ta, tw, tb;
	bq.push_back(r);
	s_axi_awaddr <= a;
	s_axi_wdata <= dt;
	s_axi_awvalid <= 1'h1;
	s_axi_wvalid <= 1'h1;
	s_axi_bready <= 1'h1;
	tb = 1'h0;
	while (!tb) begin
		@(negedge aclk);
		ta = s_axi_awvalid && s_axi_awready;
		tw = s_axi_wvalid && s_axi_wready;
		tb = s_axi_bvalid;
		@(posedge aclk);
		if (ta) s_axi_awvalid <= 1'h0;
		if (tw) s_axi_wvalid <= 1'h0;
	end
	s_axi_bready <= 1'h0;
	@(posedge aclk);
endtask
task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
	logic ta, tr;
	rq.push_back({r, e});
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'h1;
	s_axi_rready <= 1'h1;
	tr = 1'h0;
	while (!tr) begin
		@(negedge aclk);
		ta = s_axi_arvalid && s_axi_arready;
		tr = s_axi_rvalid;
		@(posedge aclk);
		if (ta) s_axi_arvalid <= 1'h0;
	end
	s_axi_rready <= 1'h0;
	@(posedge aclk);
endtask
// two edges cover the one flush cycle of jumps and taken skips
task ins(input logic [3:0] o, input logic [7:0] lo);
	wr(`CCE_ADDR_INSTR, {20'h0, o, lo}, OK);
	repeat (2) @(posedge aclk);
endtask
initial begin
	repeat (20000) @(posedge aclk);
	num_errors++;
	report_and_stop;
end
initial begin
	repeat (4) @(posedge aclk);
	aresetn <= 1'h1;
	void'($urandom(71));
	fp = 11'h000;
	rd(A_FL, 32'h18, OK);
	rd(`CCE_ADDR_CFG, 32'h0, OK);
	rd(8'h1c, 32'h0, `CCE_RESP_SLVERR);
	wr(8'h1c, 32'h5a, `CCE_RESP_SLVERR);
	$display("test reset done");
	wr(A_FL, 32'h60, OK);
	wr(A_AC, 32'h81, OK);
	ins(`CCE_OPC_CLR_ACC, 8'h00);
	rd(A_AC, 32'h0, OK);
	rd(A_FL, 32'h64, OK);
	f = 5'($urandom);
	wr({1'h1, f, 2'h0}, 32'ha5, OK);
	wr(A_FL, 32'h60, OK);
	ins(`CCE_OPC_CLR_FILE, {3'h0, f});
	fp = 11'h002;
	rd({1'h1, f, 2'h0}, 32'h0, OK);
	rd(A_FL, 32'h64, OK);
	rd(A_FP, {21'h0, fp}, OK);
	$display("test clear done");
	for (int i = 0; i < 12; i++) begin
		op = 4'h4 + 4'(i % 3);
		d = 1'((i / 3) % 2);
		v = (op == 4'h4) ? 8'hff : 8'h01;
		if (i >= 6) v = 8'($urandom);
		va = 8'($urandom);
		f = 5'($urandom);
		fl = (i % 2) ? 8'h64 : 8'h60;
		res = (op == 4'h4) ? ~v : v - `CCE_MINUS_STEP;
		wr({1'h1, f, 2'h0}, {24'h0, v}, OK);
		wr(A_AC, {24'h0, va}, OK);
		wr(A_FL, {24'h0, fl}, OK);
		ins(op, {2'h0, d, f});
		fp = fp + ((op == 4'h6 && res == 8'h00) ? 11'h002 : 11'h001);
		rd({1'h1, f, 2'h0}, {24'h0, d ? res : v}, OK);
		rd(A_AC, {24'h0, d ? va : res}, OK);
		rd(A_FL, {24'h0, fl[7:3], (op == 4'h6) ? fl[2] : res == 8'h00, fl[1:0]}, OK);
		rd(A_FP, {21'h0, fp}, OK);
	end
	$display("test file ops done");
	for (int j = 1; j < 3; j++) begin
		lit = 8'($urandom);
		fl = {1'h0, 2'(j), 5'h00};
		wr(A_FL, {24'h0, fl}, OK);
		ins(`CCE_OPC_JUMP, lit);
		rd(`CCE_ADDR_STACK, {21'h0, fp + 11'h001}, OK);
		fp = {2'(j), 1'h0, lit};
		rd(A_FP, {21'h0, fp}, OK);
		rd(A_FL, {24'h0, fl}, OK);
		rd(`CCE_ADDR_STATE, 32'h0, OK);
		ins((j == 1) ? `CCE_OPC_IDLE : 4'hf, 8'h00);
		fp = fp + 11'h001;
		rd(A_FP, {21'h0, fp}, OK);
	end
	$display("test jump done");
	for (int c = 0; c < 2; c++) begin
		wr(`CCE_ADDR_CFG, 32'(c), OK);
		wr(A_FL, 32'h0, OK);
		ins(`CCE_OPC_KICK, 8'h00);
		rd(A_FL, 32'h18, OK);
		chk("timer clears", 34'(c + 1), 34'(nk));
		chk("prescaler clears", 34'(c), 34'(np));
	end
	$display("test kick done");
	report_and_stop;
end
endmodule
`default_nettype wire
